// ### hdl/dtc_pkg.sv
// Constants and types shared by the dual timer/counter block.
package dtc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register addresses on the special function register port.
   localparam logic [7:0] ADDR_RUN_IRQ_FLAGS = 8'h88;
   localparam logic [7:0] ADDR_MODE_SELECT = 8'h89;
   localparam logic [7:0] ADDR_A_COUNT_LOW = 8'h8a;
   localparam logic [7:0] ADDR_B_COUNT_LOW = 8'h8b;
   localparam logic [7:0] ADDR_A_COUNT_HIGH = 8'h8c;
   localparam logic [7:0] ADDR_B_COUNT_HIGH = 8'h8d;
   localparam logic [7:0] ADDR_CLOCK_DIV_SEL = 8'h8e;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and the answer to an address this block does not hold.
   localparam logic [7:0] RST_RUN_IRQ_FLAGS = 8'h00;
   localparam logic [7:0] RST_MODE_SELECT = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_CLOCK_DIV_SEL = 8'h01;
   localparam logic [7:0] UNMAPPED_READ = 8'hff;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions in the clock divider select register.
   localparam int FAST_CLOCK_A_POS = 3;
   localparam int FAST_CLOCK_B_POS = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Timing counts in oscillator cycles, and the divider and prescaler widths in bits.
   localparam int DIV_SLOW = 12;
   localparam int DIV_FAST = 4;
   localparam int DIV_CNT_W = 4;
   localparam int PRESCALE_W = 5;

   ////////////////////////////////////////////////////////////////////////////
   // Synchroniser lane order.
   localparam int LANE_COUNT_A = 0;
   localparam int LANE_COUNT_B = 1;
   localparam int LANE_IRQ_A = 2;
   localparam int LANE_IRQ_B = 3;
   localparam int LANES = 4;

   typedef enum logic [1:0] {
      MODE_PRESCALED = 2'b00,
      MODE_CHAINED = 2'b01,
      MODE_RELOAD = 2'b10,
      MODE_SPLIT = 2'b11
   } dtc_mode_e;

   typedef struct packed {
      logic gate;
      logic counter_sel;
      dtc_mode_e mode;
   } dtc_tmr_ctl_s;

   typedef struct packed {
      dtc_tmr_ctl_s b;
      dtc_tmr_ctl_s a;
   } dtc_mode_sel_s;

   typedef struct packed {
      logic timer_b_overflow_flag;
      logic timer_b_run;
      logic timer_a_overflow_flag;
      logic timer_a_run;
      logic pin_b_irq_flag;
      logic pin_b_trigger_type;
      logic pin_a_irq_flag;
      logic pin_a_trigger_type;
   } dtc_flags_s;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
      logic ovf;
   } dtc_step_s;

endpackage : dtc_pkg

// ### hdl/dtc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and falling edge pulse.
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic hold_i,
   input wire logic [WIDTH-1:0] pins_i,
   output logic [WIDTH-1:0] level_o,
   output logic [WIDTH-1:0] fall_o
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] lvl_q;
   logic [WIDTH-1:0] lvl_d;
   logic [WIDTH-1:0] fall_q;
   logic [WIDTH-1:0] fall_d;

   // A lane changes only once stages two and three agree; each fall gives one pulse unless hold_i is set.
   always_comb begin
      lvl_d = lvl_q;
      fall_d = '0;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s3_q[i];
         end
         fall_d[i] = lvl_q[i] & ~lvl_d[i] & ~hold_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
         lvl_q <= '1;
         fall_q <= '0;
      end else begin
         s1_q <= pins_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
         fall_q <= fall_d;
      end
   end

   assign level_o = lvl_q;
   assign fall_o = fall_q;
endmodule : dtc_pin_sync
`default_nettype wire

// ### hdl/dtc_top.sv
// Dual timer/counter with external interrupt pin flags behind the register port.
//
// Contract
// - Timer B overflow sets its flag; vectoring or software clears it.
// - Timer A overflow sets its flag; vectoring or software clears it.
// - Run bit set lets the timer count; clear holds the count.
// - Pin B flag sets on edge or level; edge clears on vector, level follows.
// - Pin A flag sets on edge or level; edge clears on vector, level follows.
// - Trigger type bit set selects falling edge, clear selects low level.
// - Gate bit set also requires the interrupt pin high to count.
// - Counter select clear counts divided clock; set counts count pin falls.
// - Mode 00 is an 8-bit counter behind a 5-bit prescaler.
// - Mode 01 chains high and low bytes into one 16-bit counter.
// - Mode 10 counts low byte and reloads it from high byte on overflow.
// - Timer A mode 11 splits bytes; high byte uses timer B run and flag.
// - Timer B mode 11 stops timer B and holds its count.
// - Fast clock bit set divides oscillator by 4, clear divides by 12.
// - Timer A low and high bytes read and write at their own addresses.
// - Timer B low and high bytes read and write at their own addresses.
// - Idle leaves timer and interrupt logic clocked and counting.
// - Full stop freezes both timers and all hardware flag updates; acknowledges and software writes still act.
`timescale 1ns/100ps
`default_nettype none
module dtc_top #(
   parameter int DIV_SLOW_P = dtc_pkg::DIV_SLOW,
   parameter int DIV_FAST_P = dtc_pkg::DIV_FAST
) (
   input wire logic REF_CLK_I,
   input wire logic SRST_I,
   input wire logic [7:0] SFR_ADDR_I,
   input wire logic SFR_WR_I,
   input wire logic SFR_RD_I,
   input wire logic [7:0] SFR_WDATA_I,
   output logic [7:0] SFR_RDATA_O,
   input wire logic COUNT_PIN_A_I,
   input wire logic COUNT_PIN_B_I,
   input wire logic EXT_IRQ_PIN_A_I,
   input wire logic EXT_IRQ_PIN_B_I,
   input wire logic ACK_TIMER_A_I,
   input wire logic ACK_TIMER_B_I,
   input wire logic ACK_PIN_A_I,
   input wire logic ACK_PIN_B_I,
   input wire logic FULL_STOP_REQUEST_I,
   output logic TIMER_A_OVERFLOW_FLAG_O,
   output logic TIMER_B_OVERFLOW_FLAG_O,
   output logic PIN_A_IRQ_FLAG_O,
   output logic PIN_B_IRQ_FLAG_O
);
   import dtc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Functions.

   // Count enable for one timer from its controls, gate pin and clock choice.
   function automatic logic src_tick(input dtc_tmr_ctl_s ctl, input logic run_bit,
                                     input logic gate_lvl, input logic pin_fall,
                                     input logic fast, input logic t_fast,
                                     input logic t_slow);
      logic clk_tick;
      clk_tick = fast ? t_fast : t_slow;
      return run_bit & (~ctl.gate | gate_lvl) & (ctl.counter_sel ? pin_fall : clk_tick);
   endfunction : src_tick

   // One increment of a timer in the given mode, with the wrap flag.
   function automatic dtc_step_s count_step(input dtc_mode_e mode, input logic [7:0] high,
                                            input logic [7:0] low);
      dtc_step_s r;
      logic [12:0] v13;
      logic [15:0] v16;
      r.high = high;
      r.low = low;
      r.ovf = 1'b0;
      v13 = {high, low[PRESCALE_W-1:0]} + 13'h0001;
      v16 = {high, low} + 16'h0001;
      case (mode)
         MODE_PRESCALED: begin
            r.high = v13[12:PRESCALE_W];
            r.low = {low[7:PRESCALE_W], v13[PRESCALE_W-1:0]};
            r.ovf = &{high, low[PRESCALE_W-1:0]};
         end
         MODE_CHAINED: begin
            r.high = v16[15:8];
            r.low = v16[7:0];
            r.ovf = &{high, low};
         end
         MODE_RELOAD: begin
            r.ovf = &low;
            r.low = r.ovf ? high : low + 8'h01;
         end
         default: begin
            r.ovf = &low;
            r.low = low + 8'h01;
         end
      endcase
      return r;
   endfunction : count_step

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   logic run_ok;
   logic [LANES-1:0] pin_lvl;
   logic [LANES-1:0] pin_fall;

   // Idle does not reach this block at all; only the full stop request freezes it.
   assign run_ok = ~FULL_STOP_REQUEST_I;

   dtc_pin_sync #(
      .WIDTH(LANES)
   ) u_pin_sync (
      .clk_i(REF_CLK_I),
      .srst_i(SRST_I),
      .hold_i(FULL_STOP_REQUEST_I),
      .pins_i({EXT_IRQ_PIN_B_I, EXT_IRQ_PIN_A_I, COUNT_PIN_B_I, COUNT_PIN_A_I}),
      .level_o(pin_lvl),
      .fall_o(pin_fall)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator divider giving divide-by-4 and divide-by-12 enables.

   logic [DIV_CNT_W-1:0] div_q;
   logic [DIV_CNT_W-1:0] div_d;
   logic tick_fast;
   logic tick_slow;

   always_comb begin
      div_d = div_q;
      tick_slow = run_ok & (div_q == DIV_CNT_W'(DIV_SLOW_P - 1));
      tick_fast = run_ok & (div_q[1:0] == 2'(DIV_FAST_P - 1));
      if (run_ok) begin
         div_d = tick_slow ? '0 : div_q + DIV_CNT_W'(1);
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         div_q <= '0;
      end else begin
         div_q <= div_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timers, flags and register port.

   dtc_flags_s fr_q;
   dtc_flags_s fr_d;
   dtc_mode_sel_s md_q;
   dtc_mode_sel_s md_d;
   logic [7:0] ck_q;
   logic [7:0] ck_d;
   logic [7:0] a_lo_q;
   logic [7:0] a_lo_d;
   logic [7:0] a_hi_q;
   logic [7:0] a_hi_d;
   logic [7:0] b_lo_q;
   logic [7:0] b_lo_d;
   logic [7:0] b_hi_q;
   logic [7:0] b_hi_d;
   logic [7:0] rd_q;
   logic [7:0] rd_d;
   dtc_step_s step_a;
   dtc_step_s step_b;
   logic tick_a;
   logic tick_b;
   logic tick_ah;
   logic a_split;

   always_comb begin
      fr_d = fr_q;
      md_d = md_q;
      ck_d = ck_q;
      a_lo_d = a_lo_q;
      a_hi_d = a_hi_q;
      b_lo_d = b_lo_q;
      b_hi_d = b_hi_q;
      rd_d = rd_q;
      a_split = (md_q.a.mode == MODE_SPLIT);
      step_a = count_step(md_q.a.mode, a_hi_q, a_lo_q);
      step_b = count_step(md_q.b.mode, b_hi_q, b_lo_q);
      tick_a = run_ok & src_tick(md_q.a, fr_q.timer_a_run, pin_lvl[LANE_IRQ_A],
                                 pin_fall[LANE_COUNT_A], ck_q[FAST_CLOCK_A_POS],
                                 tick_fast, tick_slow);
      tick_b = run_ok & (md_q.b.mode != MODE_SPLIT) &
               src_tick(md_q.b, fr_q.timer_b_run, pin_lvl[LANE_IRQ_B],
                        pin_fall[LANE_COUNT_B], ck_q[FAST_CLOCK_B_POS],
                        tick_fast, tick_slow);
      // The split high byte is a plain timer on timer B's run bit and clock choice.
      tick_ah = run_ok & a_split & fr_q.timer_b_run &
                (ck_q[FAST_CLOCK_B_POS] ? tick_fast : tick_slow);

      if (tick_a) begin
         a_lo_d = step_a.low;
         if (!a_split) begin
            a_hi_d = step_a.high;
         end
      end
      if (tick_ah) begin
         a_hi_d = a_hi_q + 8'h01;
      end
      if (tick_b) begin
         b_lo_d = step_b.low;
         b_hi_d = step_b.high;
      end

      // Software writes win over counting for the byte written.
      if (SFR_WR_I) begin
         case (SFR_ADDR_I)
            ADDR_RUN_IRQ_FLAGS: fr_d = dtc_flags_s'(SFR_WDATA_I);
            ADDR_MODE_SELECT: md_d = dtc_mode_sel_s'(SFR_WDATA_I);
            ADDR_A_COUNT_LOW: a_lo_d = SFR_WDATA_I;
            ADDR_A_COUNT_HIGH: a_hi_d = SFR_WDATA_I;
            ADDR_B_COUNT_LOW: b_lo_d = SFR_WDATA_I;
            ADDR_B_COUNT_HIGH: b_hi_d = SFR_WDATA_I;
            ADDR_CLOCK_DIV_SEL: ck_d = SFR_WDATA_I;
            default: begin
            end
         endcase
      end

      // Vector acknowledges clear; pin flags clear only in edge mode.
      if (ACK_TIMER_A_I) begin
         fr_d.timer_a_overflow_flag = 1'b0;
      end
      if (ACK_TIMER_B_I) begin
         fr_d.timer_b_overflow_flag = 1'b0;
      end
      if (ACK_PIN_A_I && fr_q.pin_a_trigger_type) begin
         fr_d.pin_a_irq_flag = 1'b0;
      end
      if (ACK_PIN_B_I && fr_q.pin_b_trigger_type) begin
         fr_d.pin_b_irq_flag = 1'b0;
      end

      // Hardware sets come last so a set beats any clear in the same cycle.
      if (tick_a && step_a.ovf) begin
         fr_d.timer_a_overflow_flag = 1'b1;
      end
      if ((tick_b && step_b.ovf) || (tick_ah && (&a_hi_q))) begin
         fr_d.timer_b_overflow_flag = 1'b1;
      end
      if (run_ok) begin
         if (fr_q.pin_a_trigger_type) begin
            if (pin_fall[LANE_IRQ_A]) begin
               fr_d.pin_a_irq_flag = 1'b1;
            end
         end else begin
            fr_d.pin_a_irq_flag = ~pin_lvl[LANE_IRQ_A];
         end
         if (fr_q.pin_b_trigger_type) begin
            if (pin_fall[LANE_IRQ_B]) begin
               fr_d.pin_b_irq_flag = 1'b1;
            end
         end else begin
            fr_d.pin_b_irq_flag = ~pin_lvl[LANE_IRQ_B];
         end
      end

      // Read data is captured on the read strobe and held until the next one.
      if (SFR_RD_I) begin
         case (SFR_ADDR_I)
            ADDR_RUN_IRQ_FLAGS: rd_d = fr_q;
            ADDR_MODE_SELECT: rd_d = md_q;
            ADDR_A_COUNT_LOW: rd_d = a_lo_q;
            ADDR_A_COUNT_HIGH: rd_d = a_hi_q;
            ADDR_B_COUNT_LOW: rd_d = b_lo_q;
            ADDR_B_COUNT_HIGH: rd_d = b_hi_q;
            ADDR_CLOCK_DIV_SEL: rd_d = ck_q;
            default: rd_d = UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         fr_q <= dtc_flags_s'(RST_RUN_IRQ_FLAGS);
         md_q <= dtc_mode_sel_s'(RST_MODE_SELECT);
         ck_q <= RST_CLOCK_DIV_SEL;
         a_lo_q <= RST_COUNT;
         a_hi_q <= RST_COUNT;
         b_lo_q <= RST_COUNT;
         b_hi_q <= RST_COUNT;
         rd_q <= RST_COUNT;
      end else begin
         fr_q <= fr_d;
         md_q <= md_d;
         ck_q <= ck_d;
         a_lo_q <= a_lo_d;
         a_hi_q <= a_hi_d;
         b_lo_q <= b_lo_d;
         b_hi_q <= b_hi_d;
         rd_q <= rd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign SFR_RDATA_O = rd_q;
   assign TIMER_A_OVERFLOW_FLAG_O = fr_q.timer_a_overflow_flag;
   assign TIMER_B_OVERFLOW_FLAG_O = fr_q.timer_b_overflow_flag;
   assign PIN_A_IRQ_FLAG_O = fr_q.pin_a_irq_flag;
   assign PIN_B_IRQ_FLAG_O = fr_q.pin_b_irq_flag;

endmodule : dtc_top
`default_nettype wire

// ### test/dtc_pin_model.sv
// Far side model: count pins and gate pins, idle high as if pulled up.
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_model (
   input wire logic clk_i,
   input wire logic [3:0] fire_i,
   input wire logic [3:0] low_i,
   output logic [3:0] pins_o,
   output logic busy_o
);
   logic [2:0] cnt_q = 3'h0;
   logic [3:0] sel_q = 4'h0;
   // A request pulls its lanes low four cycles, then high four, so one clean fall.
   always_ff @(posedge clk_i) begin
      if (cnt_q != 3'h0) begin
         cnt_q <= cnt_q - 3'h1;
      end else if (fire_i != 4'h0) begin
         cnt_q <= 3'h7;
         sel_q <= fire_i;
      end
   end
   assign pins_o = ~low_i & ~(sel_q & {4{cnt_q[2]}});
   assign busy_o = cnt_q != 3'h0;
endmodule : dtc_pin_model
`default_nettype wire

// ### test/dtc_props.sv
// Property checker for the register port and the four flags.
`timescale 1ns/100ps
`default_nettype none
module dtc_props
   import dtc_pkg::*;
(
   input wire logic REF_CLK_I,
   input wire logic SRST_I,
   input wire logic [7:0] SFR_ADDR_I,
   input wire logic SFR_WR_I,
   input wire logic SFR_RD_I,
   input wire logic [7:0] SFR_WDATA_I,
   input wire logic [7:0] SFR_RDATA_O,
   input wire logic EXT_IRQ_PIN_A_I,
   input wire logic EXT_IRQ_PIN_B_I,
   input wire logic ACK_TIMER_A_I,
   input wire logic ACK_TIMER_B_I,
   input wire logic FULL_STOP_REQUEST_I,
   input wire logic TIMER_A_OVERFLOW_FLAG_O,
   input wire logic TIMER_B_OVERFLOW_FLAG_O,
   input wire logic PIN_A_IRQ_FLAG_O,
   input wire logic PIN_B_IRQ_FLAG_O
);
   logic wr_f, rd_f, set_a, set_b;
   logic type_a_q = 1'b0;
   logic type_b_q = 1'b0;
   assign wr_f = SFR_WR_I && SFR_ADDR_I == ADDR_RUN_IRQ_FLAGS;
   assign rd_f = SFR_RD_I && SFR_ADDR_I == ADDR_RUN_IRQ_FLAGS;
   assign set_a = wr_f && SFR_WDATA_I[5];
   assign set_b = wr_f && SFR_WDATA_I[7];
   // Shadow of the trigger type bits, which only software writes.
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         type_a_q <= 1'b0;
         type_b_q <= 1'b0;
      end else if (wr_f) begin
         type_a_q <= SFR_WDATA_I[0];
         type_b_q <= SFR_WDATA_I[2];
      end
   end
   sequence s_a_low;
      (!EXT_IRQ_PIN_A_I && !FULL_STOP_REQUEST_I && !type_a_q && !wr_f)[*8];
   endsequence
   sequence s_b_high;
      (EXT_IRQ_PIN_B_I && !FULL_STOP_REQUEST_I && !type_b_q && !wr_f)[*8];
   endsequence
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SRST_I);
   chk_unmapped_read:
   assert property (SFR_RD_I && (SFR_ADDR_I < ADDR_RUN_IRQ_FLAGS ||
      SFR_ADDR_I > ADDR_CLOCK_DIV_SEL) |=> SFR_RDATA_O == UNMAPPED_READ)
      else $error("unmapped read not all ones");
   chk_rdata_hold:
   assert property (!SFR_RD_I |=> $stable(SFR_RDATA_O))
      else $error("read data moved without a read");
   chk_wr_set_a:
   assert property (set_a && !ACK_TIMER_A_I |=> TIMER_A_OVERFLOW_FLAG_O)
      else $error("write did not set timer a flag");
   chk_wr_set_b:
   assert property (set_b && !ACK_TIMER_B_I |=> TIMER_B_OVERFLOW_FLAG_O)
      else $error("write did not set timer b flag");
   chk_stop_no_set:
   assert property ($rose(TIMER_A_OVERFLOW_FLAG_O) && $past(FULL_STOP_REQUEST_I) |-> $past(set_a))
      else $error("timer a flag set by hardware while stopped");
   chk_stop_ack_b:
   assert property (ACK_TIMER_B_I && FULL_STOP_REQUEST_I |=> !TIMER_B_OVERFLOW_FLAG_O)
      else $error("ack did not clear timer b flag");
   chk_pin_a_low:
   assert property (s_a_low |-> PIN_A_IRQ_FLAG_O)
      else $error("low pin a not flagged");
   chk_pin_b_high:
   assert property (s_b_high |-> !PIN_B_IRQ_FLAG_O)
      else $error("high pin b still flagged");
   chk_flag_readback:
   assert property (rd_f |=> SFR_RDATA_O[5] == $past(TIMER_A_OVERFLOW_FLAG_O) &&
      SFR_RDATA_O[3] == $past(PIN_B_IRQ_FLAG_O))
      else $error("flag read differs from flag outputs");
endmodule : dtc_props
bind dtc_top dtc_props i_props (.*);
`default_nettype wire

// ### test/test_dtc_top.sv
// Self-checking bench for the dual timer/counter.
`timescale 1ns/100ps
`default_nettype none
module test_dtc_top;
   import dtc_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_d = 1'b0;
   logic stop = 1'b0;
   logic busy;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic [7:0] lfsr = 8'h19;
   logic [3:0] ack = 4'h0;
   logic [3:0] fire = 4'h0;
   logic [3:0] low = 4'h0;
   logic [3:0] pins;
   logic [3:0] flg;
   logic [7:0] ra_d = 8'h00;
   logic [15:0] exp_q[$];
   logic [15:0] e;
   logic [15:0] rst_tab[9] = '{16'h8800, 16'h8900, 16'h8a00, 16'h8b00, 16'h8c00,
      16'h8d00, 16'h8e01, 16'h80ff, 16'h8fff};
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int d;
   dtc_top #(.DIV_SLOW_P(DIV_SLOW), .DIV_FAST_P(DIV_FAST)) i_dut (
      .REF_CLK_I(clk), .SRST_I(srst), .SFR_ADDR_I(addr), .SFR_WR_I(wr), .SFR_RD_I(rd),
      .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata), .COUNT_PIN_A_I(pins[0]),
      .COUNT_PIN_B_I(pins[1]), .EXT_IRQ_PIN_A_I(pins[2]), .EXT_IRQ_PIN_B_I(pins[3]),
      .ACK_TIMER_A_I(ack[0]), .ACK_TIMER_B_I(ack[1]), .ACK_PIN_A_I(ack[2]),
      .ACK_PIN_B_I(ack[3]), .FULL_STOP_REQUEST_I(stop), .TIMER_A_OVERFLOW_FLAG_O(flg[0]),
      .TIMER_B_OVERFLOW_FLAG_O(flg[1]), .PIN_A_IRQ_FLAG_O(flg[2]), .PIN_B_IRQ_FLAG_O(flg[3]));
   dtc_pin_model i_pins (.clk_i(clk), .fire_i(fire), .low_i(low), .pins_o(pins), .busy_o(busy));
   initial begin
      forever #5 clk = ~clk;
   end
   function automatic logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : nxt
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // Notes the accepted range, then reads; the monitor compares a cycle later.
   task automatic chk(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
      @(posedge clk);
      exp_q.push_back({lo, hi});
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask : chk
   task automatic pulse(input logic [3:0] m, input int n);
      repeat (n) begin
         @(posedge clk);
         fire <= m;
         @(posedge clk);
         fire <= 4'h0;
         @(posedge clk);
         while (busy) @(posedge clk);
      end
      repeat (6) @(posedge clk);
   endtask : pulse
   task automatic ackp(input logic [3:0] m);
      @(posedge clk);
      ack <= m;
      @(posedge clk);
      ack <= 4'h0;
   endtask : ackp
   always @(posedge clk) begin
      rd_d <= rd;
      ra_d <= addr;
      cycles++;
      if (cycles == 5000) begin
         errors++;
         conclude();
      end
   end
   always @(negedge clk) begin
      if (rd_d) begin
         e = exp_q.pop_front();
         num_checks++;
         if (!((rdata >= e[15:8]) === 1'b1 && (rdata <= e[7:0]) === 1'b1)) begin
            errors++;
            $display("BAD %0t read %h want %h..%h", $time, rdata, e[15:8], e[7:0]);
         end
         // A flag register read also holds the four flag outputs to the same bits.
         if (ra_d == 8'h88) begin
            num_checks++;
            if (flg !== {e[11], e[9], e[15], e[13]}) begin
               errors++;
               $display("BAD %0t flag outputs %b want %b", $time, flg, {e[11], e[9], e[15], e[13]});
            end
         end
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      foreach (rst_tab[i]) chk(rst_tab[i][15:8], rst_tab[i][7:0], rst_tab[i][7:0]);
      for (int i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         wr_reg(8'h8a + 8'(i), lfsr);
         chk(8'h8a + 8'(i), lfsr, lfsr);
      end
      $display("test registers done");
      wr_reg(8'h88, 8'ha0);
      chk(8'h88, 8'ha0, 8'ha0);
      wr_reg(8'h89, 8'h06);
      wr_reg(8'h8c, 8'h40);
      wr_reg(8'h8a, 8'hfe);
      wr_reg(8'h88, 8'h10);
      pulse(4'h1, 2);
      chk(8'h8a, 8'h40, 8'h40);
      chk(8'h88, 8'h30, 8'h30);
      ackp(4'h1);
      chk(8'h88, 8'h10, 8'h10);
      wr_reg(8'h88, 8'h00);
      pulse(4'h1, 1);
      chk(8'h8a, 8'h40, 8'h40);
      $display("test reload done");
      wr_reg(8'h89, 8'h0e);
      wr_reg(8'h88, 8'h10);
      low <= 4'h4;
      pulse(4'h1, 1);
      chk(8'h8a, 8'h40, 8'h40);
      ackp(4'h4);
      chk(8'h88, 8'h12, 8'h12);
      low <= 4'h0;
      pulse(4'h1, 1);
      chk(8'h8a, 8'h41, 8'h41);
      chk(8'h88, 8'h10, 8'h10);
      wr_reg(8'h88, 8'h04);
      pulse(4'h8, 1);
      chk(8'h88, 8'h0c, 8'h0c);
      ackp(4'h8);
      chk(8'h88, 8'h04, 8'h04);
      wr_reg(8'h88, 8'h01);
      pulse(4'h4, 1);
      chk(8'h88, 8'h03, 8'h03);
      ackp(4'h4);
      chk(8'h88, 8'h01, 8'h01);
      $display("test gate and pins done");
      wr_reg(8'h89, 8'h40);
      wr_reg(8'h8b, 8'hfe);
      wr_reg(8'h8d, 8'hff);
      wr_reg(8'h88, 8'h40);
      pulse(4'h2, 2);
      chk(8'h8b, 8'he0, 8'he0);
      chk(8'h8d, 8'h00, 8'h00);
      chk(8'h88, 8'hc0, 8'hc0);
      wr_reg(8'h89, 8'h70);
      pulse(4'h2, 1);
      chk(8'h8b, 8'he0, 8'he0);
      wr_reg(8'h89, 8'h50);
      wr_reg(8'h8b, 8'hff);
      wr_reg(8'h8d, 8'h12);
      stop <= 1'b1;
      pulse(4'h2, 1);
      ackp(4'h2);
      chk(8'h8b, 8'hff, 8'hff);
      chk(8'h88, 8'h40, 8'h40);
      wr_reg(8'h88, 8'h60);
      chk(8'h88, 8'h60, 8'h60);
      stop <= 1'b0;
      pulse(4'h2, 1);
      chk(8'h8b, 8'h00, 8'h00);
      chk(8'h8d, 8'h13, 8'h13);
      $display("test modes done");
      wr_reg(8'h89, 8'h11);
      for (int f = 0; f < 2; f++) begin
         d = (f == 0) ? DIV_FAST : DIV_SLOW;
         wr_reg(8'h8e, (f == 0) ? 8'h19 : 8'h01);
         wr_reg(8'h8a, 8'h00);
         wr_reg(8'h8b, 8'h00);
         wr_reg(8'h88, 8'h50);
         repeat (240) @(posedge clk);
         wr_reg(8'h88, 8'h00);
         chk(8'h8a, 8'(240 / d - 2), 8'(240 / d + 2));
         chk(8'h8b, 8'(240 / d - 2), 8'(240 / d + 2));
      end
      $display("test clock rate done");
      // Timer A split, timer B stopped; the high byte runs on timer B's run bit.
      wr_reg(8'h89, 8'h37);
      wr_reg(8'h8a, 8'hff);
      wr_reg(8'h8c, 8'hff);
      wr_reg(8'h88, 8'h50);
      pulse(4'h1, 1);
      chk(8'h8a, 8'h00, 8'h00);
      chk(8'h88, 8'hf0, 8'hf0);
      wr_reg(8'h88, 8'h00);
      chk(8'h8c, 8'h00, 8'h02);
      $display("test split mode done");
      repeat (3) @(posedge clk);
      conclude();
   end
endmodule : test_dtc_top
`default_nettype wire
